//--- rtl/fsps_top.v
// flash self-programming sequencer: latches, address capture, unlock and timed cycle
`timescale 1ns/1ps
`include "fsps_consts.vh"
module fsps_top #(
	parameter            PANELS    = 2,
	parameter            CNT_W     = 20,
	parameter [CNT_W-1:0] OP_CYCLES = `FSPS_OP_CYCLES
) (
	input  wire        mclk_i,
	input  wire        rst_n_i,
	// special function register access
	input  wire        sfr_wr_i,
	input  wire        sfr_rd_i,
	input  wire [15:0] sfr_addr_i,
	input  wire [1:0]  sfr_be_i,
	input  wire [15:0] sfr_wdata_i,
	output reg  [15:0] sfr_rdata_o,
	output reg         sfr_rvalid_o,
	// table fetch / store from the core
	input  wire        tbl_valid_i,
	input  wire        tbl_store_i,
	input  wire        tbl_high_i,
	input  wire        tbl_byte_i,
	input  wire [7:0]  table_page_register_i,
	input  wire [15:0] operand_pointer_offset_i,
	input  wire [15:0] tbl_wdata_i,
	output reg  [15:0] tbl_rdata_o,
	output reg         tbl_done_o,
	// flash array side
	output reg         flash_rd_o,
	output reg  [23:0] flash_raddr_o,
	input  wire [23:0] flash_rdata_i,
	output reg         flash_erase_o,
	output reg  [17:0] flash_row_o,
	output reg         flash_wr_o,
	output reg  [23:0] flash_waddr_o,
	output reg  [23:0] flash_wdata_o,
	// system
	input  wire        ext_abort_i,
	input  wire        done_clr_i,
	output reg         core_stall_o,
	output reg         flash_done_irq_flag_o
);
	localparam PW = (PANELS > 1) ? $clog2(PANELS) : 1;
	localparam AW = PW + 5;
	localparam DEPTH = PANELS * `FSPS_ROW_WORDS;
	localparam [31:0] ROW_LAST = `FSPS_ROW_WORDS - 1;
	localparam [4:0] LAST_IDX = ROW_LAST[4:0];
	localparam [CNT_W-1:0] LAST_CNT = OP_CYCLES - {{(CNT_W-1){1'b0}}, 1'b1};

	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_BUSY = 2'b10;
	localparam [2:0] KS_LOCK = 3'b001;
	localparam [2:0] KS_HALF = 3'b010;
	localparam [2:0] KS_OPEN = 3'b100;

	reg  [1:0]       st_q;
	reg  [2:0]       ks_q;
	reg              go_q;
	reg              program_enable_bit_q;
	reg              err_q;
	reg              erase_q;
	reg  [3:0]       type_q;
	reg  [15:0]      adr_low_q;
	reg  [7:0]       adr_up_q;
	reg  [CNT_W-1:0] cnt_q;
	reg              run_q;
	reg  [4:0]       idx_q;
	reg              rv1_q;
	reg  [4:0]       idx1_q;
	reg              tbl_p1_q;
	reg              f_pend_q;
	reg              f_high_q;
	reg              f_byte_q;
	reg              f_odd_q;

	wire busy = st_q[1];
	wire tbl_take = tbl_valid_i & ~tbl_p1_q & ~busy;
	wire [23:0] ea = {table_page_register_i, operand_pointer_offset_i};
	wire odd = operand_pointer_offset_i[0];

	wire hit_ctrl = sfr_addr_i == `FSPS_ADR_CTRL;
	wire hit_low  = sfr_addr_i == `FSPS_ADR_LOW;
	wire hit_up   = sfr_addr_i == `FSPS_ADR_UP;
	wire hit_key  = sfr_addr_i == `FSPS_ADR_KEY;

	// write latches: panel from the address, word index from offset bits 5..1
	wire          st_we = tbl_take & tbl_store_i;
	wire [AW-1:0] st_waddr = {ea[`FSPS_PANEL_LSB +: PW], ea[5:1]};
	reg  [2:0]    st_be;
	reg  [23:0]   st_wdata;
	always @* begin
		if (tbl_high_i) begin
			st_wdata = {tbl_wdata_i[7:0], 16'h0000};
			st_be    = (tbl_byte_i && odd) ? 3'b000 : 3'b100;
		end else if (tbl_byte_i) begin
			st_wdata = {8'h00, tbl_wdata_i[7:0], tbl_wdata_i[7:0]};
			st_be    = odd ? 3'b010 : 3'b001;
		end else begin
			st_wdata = {8'h00, tbl_wdata_i};
			st_be    = 3'b011;
		end
	end

	// programming reads the latches of the panel that the address registers select
	wire [AW-1:0] rd_addr = {adr_low_q[`FSPS_PANEL_LSB +: PW], idx_q};
	wire [23:0] latch_rdata;

	fsps_latch_mem #(
		.AW    (AW),
		.DEPTH (DEPTH)
	) u_latch (
		.mclk_i  (mclk_i),
		.we_i    (st_we),
		.be_i    (st_be),
		.waddr_i (st_waddr),
		.wdata_i (st_wdata),
		.raddr_i (rd_addr),
		.rdata_o (latch_rdata)
	);

	// control write decode; the go bit needs its own byte lane
	wire ctrl_wr = sfr_wr_i & hit_ctrl;
	wire new_program_enable_bit = sfr_be_i[1] ? sfr_wdata_i[`FSPS_CTRL_PROGRAM_ENABLE_BIT] : program_enable_bit_q;
	wire [3:0] new_type = sfr_be_i[0] ?
		sfr_wdata_i[`FSPS_CTRL_TYPE_HI:`FSPS_CTRL_TYPE_LO] : type_q;
	wire new_erase = sfr_be_i[0] ? sfr_wdata_i[`FSPS_CTRL_ERASE] : erase_q;
	wire start = ctrl_wr & sfr_be_i[1] & sfr_wdata_i[`FSPS_CTRL_GO] & ks_q[2] & new_program_enable_bit
		& (new_type == `FSPS_TYPE_ROW) & ~busy & ~ext_abort_i;
	wire finish = busy & (cnt_q == LAST_CNT) & ~ext_abort_i;
	wire abort = busy & ext_abort_i;

	// unlock sequence
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ks_q <= KS_LOCK;
		end else if (sfr_wr_i) begin
			case (ks_q)
				KS_HALF: begin
					ks_q <= (hit_key && sfr_be_i[0] && sfr_wdata_i[7:0] == `FSPS_KEY2) ?
						KS_OPEN : KS_LOCK;
				end
				default: begin
					ks_q <= (hit_key && sfr_be_i[0] && sfr_wdata_i[7:0] == `FSPS_KEY1) ?
						KS_HALF : KS_LOCK;
				end
			endcase
		end
	end

	// control register and cycle sequencer
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st_q    <= ST_IDLE;
			go_q    <= 1'b0;
			program_enable_bit_q  <= 1'b0;
			err_q   <= 1'b0;
			erase_q <= 1'b0;
			type_q  <= 4'h0;
			cnt_q   <= {CNT_W{1'b0}};
			run_q   <= 1'b0;
			idx_q   <= 5'h00;
			flash_erase_o <= 1'b0;
			flash_row_o   <= 18'h00000;
			core_stall_o  <= 1'b0;
		end else begin
			flash_erase_o <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (ctrl_wr) begin
						if (sfr_be_i[1]) begin
							program_enable_bit_q <= sfr_wdata_i[`FSPS_CTRL_PROGRAM_ENABLE_BIT];
							err_q  <= sfr_wdata_i[`FSPS_CTRL_ERR];
						end
						erase_q <= new_erase;
						type_q  <= new_type;
					end
					if (start) begin
						st_q  <= ST_BUSY;
						go_q  <= 1'b1;
						cnt_q <= {CNT_W{1'b0}};
						core_stall_o  <= 1'b1;
						flash_row_o   <= {adr_up_q, adr_low_q[15:`FSPS_ROW_LSB]};
						flash_erase_o <= new_erase;
						run_q <= ~new_erase;
						idx_q <= 5'h00;
					end
				end
				ST_BUSY: begin
					// control writes are dropped while busy, so go cannot be cleared
					cnt_q <= cnt_q + 1'b1;
					if (run_q) begin
						idx_q <= idx_q + 1'b1;
						if (idx_q == LAST_IDX) begin
							run_q <= 1'b0;
						end
					end
					if (abort) begin
						st_q  <= ST_IDLE;
						go_q  <= 1'b0;
						err_q <= 1'b1;
						run_q <= 1'b0;
						core_stall_o <= 1'b0;
					end else if (finish) begin
						st_q  <= ST_IDLE;
						go_q  <= 1'b0;
						run_q <= 1'b0;
						core_stall_o <= 1'b0;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// program stream: latch word read one cycle, then driven to the array
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rv1_q  <= 1'b0;
			idx1_q <= 5'h00;
			flash_wr_o    <= 1'b0;
			flash_waddr_o <= 24'h000000;
			flash_wdata_o <= 24'h000000;
		end else begin
			rv1_q  <= run_q & busy & ~ext_abort_i;
			idx1_q <= idx_q;
			flash_wr_o <= rv1_q & busy & ~ext_abort_i;
			if (rv1_q) begin
				flash_waddr_o <= {flash_row_o, idx1_q, 1'b0};
				flash_wdata_o <= latch_rdata;
			end
		end
	end

	// address capture from table ops or direct writes; abort leaves it alone
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			adr_low_q <= `FSPS_ADDR_RST;
			adr_up_q  <= 8'h00;
		end else if (tbl_take) begin
			adr_low_q <= operand_pointer_offset_i;
			adr_up_q  <= table_page_register_i;
		end else if (sfr_wr_i && !busy) begin
			if (hit_low && sfr_be_i[0]) begin
				adr_low_q[7:0] <= sfr_wdata_i[7:0];
			end
			if (hit_low && sfr_be_i[1]) begin
				adr_low_q[15:8] <= sfr_wdata_i[15:8];
			end
			if (hit_up && sfr_be_i[0]) begin
				adr_up_q <= sfr_wdata_i[7:0];
			end
		end
	end

	// table op pipeline: taken in cycle 0, answered in cycle 2
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tbl_p1_q <= 1'b0;
			f_pend_q <= 1'b0;
			f_high_q <= 1'b0;
			f_byte_q <= 1'b0;
			f_odd_q  <= 1'b0;
			flash_rd_o    <= 1'b0;
			flash_raddr_o <= 24'h000000;
			tbl_done_o    <= 1'b0;
			tbl_rdata_o   <= 16'h0000;
		end else begin
			tbl_p1_q   <= tbl_take;
			tbl_done_o <= tbl_p1_q;
			flash_rd_o <= tbl_take & ~tbl_store_i;
			f_pend_q   <= tbl_take & ~tbl_store_i;
			if (tbl_take) begin
				flash_raddr_o <= {ea[23:1], 1'b0};
				f_high_q <= tbl_high_i;
				f_byte_q <= tbl_byte_i;
				f_odd_q  <= odd;
			end
			if (f_pend_q) begin
				if (f_high_q) begin
					tbl_rdata_o <= (f_byte_q && f_odd_q) ? 16'h0000 :
						{8'h00, flash_rdata_i[23:16]};
				end else if (f_byte_q) begin
					tbl_rdata_o <= {8'h00, f_odd_q ? flash_rdata_i[15:8] :
						flash_rdata_i[7:0]};
				end else begin
					tbl_rdata_o <= flash_rdata_i[15:0];
				end
			end else if (tbl_p1_q) begin
				tbl_rdata_o <= 16'h0000;
			end
		end
	end

	// completion flag: a new completion wins over a clear in the same cycle
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			flash_done_irq_flag_o <= 1'b0;
		end else if (finish) begin
			flash_done_irq_flag_o <= 1'b1;
		end else if (done_clr_i) begin
			flash_done_irq_flag_o <= 1'b0;
		end
	end

	// register reads, one cycle later; key and unmapped addresses read zero
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sfr_rvalid_o <= 1'b0;
			sfr_rdata_o  <= `FSPS_CTRL_RST;
		end else begin
			sfr_rvalid_o <= sfr_rd_i;
			if (sfr_rd_i) begin
				if (hit_ctrl) begin
					sfr_rdata_o <= {go_q, program_enable_bit_q, err_q, 6'h00, erase_q, 2'b00, type_q};
				end else if (hit_low) begin
					sfr_rdata_o <= adr_low_q;
				end else if (hit_up) begin
					sfr_rdata_o <= {8'h00, adr_up_q};
				end else begin
					sfr_rdata_o <= 16'h0000;
				end
			end
		end
	end
endmodule // fsps_top

//--- rtl/fsps_consts.vh
// constants of the flash self-programming sequencer
`ifndef FSPS_CONSTS_VH
`define FSPS_CONSTS_VH

// special function register addresses
`define FSPS_ADR_CTRL     16'h0760
`define FSPS_ADR_LOW      16'h0762
`define FSPS_ADR_UP       16'h0764
`define FSPS_ADR_KEY      16'h0766

// control register fields
`define FSPS_CTRL_GO      15
`define FSPS_CTRL_PROGRAM_ENABLE_BIT    14
`define FSPS_CTRL_ERR     13
`define FSPS_CTRL_ERASE   6
`define FSPS_CTRL_TYPE_HI 3
`define FSPS_CTRL_TYPE_LO 0
`define FSPS_TYPE_ROW     4'h1

// reset values
`define FSPS_CTRL_RST     16'h0000
`define FSPS_ADDR_RST     16'h0000

// unlock keys
`define FSPS_KEY1         8'h55
`define FSPS_KEY2         8'haa

// geometry
`define FSPS_ROW_WORDS    32
`define FSPS_PANEL_ROWS   128
`define FSPS_WORD_BITS    24
`define FSPS_ROW_LSB      6
`define FSPS_PANEL_LSB    13

// timing
`define FSPS_CLK_MHZ      200
`define FSPS_OP_TIME_US   2000
`define FSPS_OP_CYCLES    (`FSPS_OP_TIME_US * `FSPS_CLK_MHZ)
`define FSPS_TBL_CYCLES   2

`endif

//--- rtl/fsps_latch_mem.v
// row write latch memory, three byte lanes, registered read
`timescale 1ns/1ps
module fsps_latch_mem #(
	parameter AW    = 6,
	parameter DEPTH = 64
) (
	input  wire          mclk_i,
	input  wire          we_i,
	input  wire [2:0]    be_i,
	input  wire [AW-1:0] waddr_i,
	input  wire [23:0]   wdata_i,
	input  wire [AW-1:0] raddr_i,
	output wire [23:0]   rdata_o
);
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_lane
			reg [7:0] lane [0:DEPTH-1];
			reg [7:0] rd_q;
			always @(posedge mclk_i) begin
				if (we_i && be_i[g]) begin
					lane[waddr_i] <= wdata_i[g*8 +: 8];
				end
				rd_q <= lane[raddr_i];
			end
			assign rdata_o[g*8 +: 8] = rd_q;
		end
	endgenerate
endmodule // fsps_latch_mem

//--- verification/fsps_flash_model.sv
// program flash array model answering reads in the same cycle
`timescale 1ns/1ps
module fsps_flash_model (
	input  wire        mclk_i,
	input  wire        flash_rd_i,
	input  wire [23:0] flash_raddr_i,
	output wire [23:0] flash_rdata_o
);
	reg [23:0] junk_q = 24'h5a5a5a;
	// off a read the lines wander so a stale word can never pass
	always @(posedge mclk_i) begin
		junk_q <= ~junk_q;
	end
	assign flash_rdata_o = flash_rd_i ? {flash_raddr_i[7:0] ^ 8'hc3, flash_raddr_i[23:8]}
		: junk_q;
endmodule // fsps_flash_model

//--- verification/fsps_chk.sv
// port assertions for the self-programming sequencer
`timescale 1ns/1ps
`include "fsps_consts.vh"
module fsps_chk #(
	parameter OP_CYCLES = 64
) (
	input wire        mclk_i,
	input wire        rst_n_i,
	input wire        sfr_wr_i,
	input wire [15:0] sfr_addr_i,
	input wire [15:0] sfr_wdata_i,
	input wire        tbl_valid_i,
	input wire        tbl_store_i,
	input wire [7:0]  table_page_register_i,
	input wire [15:0] operand_pointer_offset_i,
	input wire        tbl_done_o,
	input wire        flash_rd_o,
	input wire [23:0] flash_raddr_o,
	input wire        flash_erase_o,
	input wire        flash_wr_o,
	input wire        ext_abort_i,
	input wire        done_clr_i,
	input wire        core_stall_o,
	input wire        flash_done_irq_flag_o
);
	reg        tk_q;
	reg [19:0] cnt_q;
	// a request right after a taken one is dropped, so takes are tracked
	wire       tk = tbl_valid_i & ~core_stall_o & ~tk_q;
	always @(posedge mclk_i) begin
		tk_q  <= rst_n_i & tk;
		cnt_q <= (rst_n_i & core_stall_o) ? cnt_q + 20'h1 : 20'h0;
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_tbl_answer: assert property (tk |-> ##2 tbl_done_o)
		else $error("table op answer late");
	a_fetch_addr: assert property (tk && !tbl_store_i |=> flash_rd_o && flash_raddr_o
		== ({$past(table_page_register_i), $past(operand_pointer_offset_i)} & 24'hfffffe))
		else $error("fetch address wrong");
	a_stall_len: assert property ($fell(core_stall_o) && !$past(ext_abort_i)
		|-> cnt_q == OP_CYCLES) else $error("cycle length wrong");
	a_done_on_end: assert property ($fell(core_stall_o) && !$past(ext_abort_i)
		|-> flash_done_irq_flag_o) else $error("done flag missing");
	a_done_sticky: assert property (flash_done_irq_flag_o && !done_clr_i
		|=> flash_done_irq_flag_o) else $error("done flag dropped");
	a_abort_ends: assert property (core_stall_o && ext_abort_i |=> !core_stall_o)
		else $error("abort ignored");
	a_array_stalled: assert property (flash_wr_o || flash_erase_o |-> core_stall_o)
		else $error("array touched outside a cycle");
	a_start_cause: assert property ($rose(core_stall_o) |-> $past(sfr_wr_i) &&
		$past(sfr_addr_i) == `FSPS_ADR_CTRL && ($past(sfr_wdata_i) & 16'hc000) == 16'hc000)
		else $error("cycle started without go and enable");
endmodule // fsps_chk
bind fsps_top fsps_chk #(.OP_CYCLES(OP_CYCLES)) i_chk (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_wr_i(sfr_wr_i), .sfr_addr_i(sfr_addr_i),
	.sfr_wdata_i(sfr_wdata_i), .tbl_valid_i(tbl_valid_i), .tbl_store_i(tbl_store_i),
	.table_page_register_i(table_page_register_i),
	.operand_pointer_offset_i(operand_pointer_offset_i), .tbl_done_o(tbl_done_o),
	.flash_rd_o(flash_rd_o), .flash_raddr_o(flash_raddr_o), .flash_erase_o(flash_erase_o),
	.flash_wr_o(flash_wr_o), .ext_abort_i(ext_abort_i), .done_clr_i(done_clr_i),
	.core_stall_o(core_stall_o), .flash_done_irq_flag_o(flash_done_irq_flag_o)
);

//--- verification/fsps_top_tb.sv
// self-checking bench for the self-programming sequencer
`timescale 1ns/1ps
`include "fsps_consts.vh"
module fsps_top_tb;
	localparam [15:0] A_CTL = `FSPS_ADR_CTRL;
	localparam [15:0] A_LOW = `FSPS_ADR_LOW;
	localparam [15:0] A_UP  = `FSPS_ADR_UP;
	localparam [15:0] A_KEY = `FSPS_ADR_KEY;
	reg        mclk = 0, rst_n = 0, swr = 0, srd = 0, tv = 0, tst = 0, thi = 0, tby = 0;
	reg        abrt = 0, dclr = 0;
	reg [15:0] sa = 0, swd = 0, off = 0, twd = 0, d, base;
	reg [7:0]  pg = 0;
	reg [23:0] lat [0:31];
	reg [23:0] w, n, nw = 0, nb = 0;
	reg [17:0] erow, arow;
	reg [31:0] r;
	wire [15:0] sdat, trd;
	wire        srv, tdone, frd, fer, fwr, stall, dflag;
	wire [23:0] fra, frdat, fwa, fwd;
	wire [17:0] frow;
	integer     error_cnt = 0, tests_run = 0, k;
	always #2.5 mclk = ~mclk;
	fsps_top #(.OP_CYCLES(20'd64)) i_dut (
		.mclk_i(mclk), .rst_n_i(rst_n), .sfr_wr_i(swr), .sfr_rd_i(srd), .sfr_addr_i(sa),
		.sfr_be_i(2'b11), .sfr_wdata_i(swd), .sfr_rdata_o(sdat), .sfr_rvalid_o(srv),
		.tbl_valid_i(tv), .tbl_store_i(tst), .tbl_high_i(thi), .tbl_byte_i(tby),
		.table_page_register_i(pg), .operand_pointer_offset_i(off), .tbl_wdata_i(twd),
		.tbl_rdata_o(trd), .tbl_done_o(tdone), .flash_rd_o(frd), .flash_raddr_o(fra),
		.flash_rdata_i(frdat), .flash_erase_o(fer), .flash_row_o(frow), .flash_wr_o(fwr),
		.flash_waddr_o(fwa), .flash_wdata_o(fwd), .ext_abort_i(abrt), .done_clr_i(dclr),
		.core_stall_o(stall), .flash_done_irq_flag_o(dflag)
	);
	fsps_flash_model i_flash (.mclk_i(mclk), .flash_rd_i(frd), .flash_raddr_i(fra),
		.flash_rdata_o(frdat));
	function [31:0] lfsr(input [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function [23:0] fw(input [23:0] a);
		fw = {a[7:0] ^ 8'hc3, a[23:8]};
	endfunction
	task chk(input [79:0] nm, input [23:0] s, input [23:0] e);
		begin
			tests_run = tests_run + 1;
			if (s !== e) begin
				error_cnt = error_cnt + 1;
				$display("[FAIL] %0s exp %h got %h", nm, e, s);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d errors %0d", tests_run, error_cnt);
			if (error_cnt == 0 && tests_run > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task sfr_w(input [15:0] a, input [15:0] v);
		begin
			sa <= a;
			swd <= v;
			swr <= 1'b1;
			@(posedge mclk);
			swr <= 1'b0;
			@(posedge mclk);
		end
	endtask
	task sfr_r(input [15:0] a, output [15:0] v);
		integer i;
		begin
			sa <= a;
			srd <= 1'b1;
			@(posedge mclk);
			srd <= 1'b0;
			i = 1;
			@(negedge mclk);
			while (i < 5 && srv !== 1'b1) begin
				i = i + 1;
				@(negedge mclk);
			end
			v = sdat;
			chk("rvalid", i, 1);
			if (srv !== 1'b1)
				end_of_test;
			@(posedge mclk);
		end
	endtask
	task tbl(input s, input h, input b, input [15:0] o, input [15:0] v);
		integer i;
		begin
			tst <= s;
			thi <= h;
			tby <= b;
			off <= o;
			twd <= v;
			tv <= 1'b1;
			@(posedge mclk);
			tv <= 1'b0;
			i = 1;
			@(negedge mclk);
			while (i < 6 && tdone !== 1'b1) begin
				i = i + 1;
				@(negedge mclk);
			end
			chk("tbl_wait", i, 2);
			if (tdone !== 1'b1)
				end_of_test;
			@(posedge mclk);
		end
	endtask
	task run(input [15:0] c, input [1:0] m);
		begin
			sfr_w(A_KEY, 16'h0055);
			sfr_w(A_KEY, 16'h00aa);
			sa <= A_CTL;
			swd <= c;
			swr <= 1'b1;
			@(posedge mclk);
			swr <= 1'b0;
			if (m == 2)
				abrt <= 1'b1;
			if (m == 1) begin
				@(posedge mclk);
				sfr_w(A_CTL, 16'h0000);
				sfr_r(A_CTL, d);
				chk("go_held", d[15], 1);
			end
			// stall is counted at falling edges, one count per cycle it stands
			n = 0;
			@(negedge mclk);
			while (stall === 1'b1 && n < 999) begin
				n = n + 1;
				@(posedge mclk);
				abrt <= 1'b0;
				@(negedge mclk);
			end
			if (n == 999) begin
				error_cnt = error_cnt + 1;
				end_of_test;
			end
			@(posedge mclk);
			abrt <= 1'b0;
		end
	endtask
	task clr_done;
		begin
			chk("done_flag", dflag, 1);
			dclr <= 1'b1;
			@(posedge mclk);
			dclr <= 1'b0;
			@(posedge mclk);
			chk("done_clr", dflag, 0);
		end
	endtask
	// the array model cannot tell which word was meant, so words are judged here
	always @(negedge mclk) begin
		if (fwr === 1'b1) begin
			nw = nw + 1;
			if (fwd !== lat[fwa[5:1]] || fwa[23:6] !== arow)
				nb = nb + 1;
		end
		if (fer === 1'b1)
			erow = frow;
	end
	initial begin
		r = 32'h5ed75ea6;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		for (k = 0; k < 5; k = k + 1) begin
			sfr_r(A_CTL + {k[14:0], 1'b0}, d);
			chk("reset_val", d, 0);
		end
		r = lfsr(r);
		sfr_w(A_LOW, r[15:0]);
		sfr_w(A_UP, r[31:16]);
		sfr_r(A_LOW, d);
		chk("addr_low", d, r[15:0]);
		sfr_r(A_UP, d);
		chk("addr_up", d, r[23:16]);
		pg <= r[7:0];
		for (k = 0; k < 3; k = k + 1) begin
			tbl(1'b0, k == 1, k == 2, {r[31:17], k == 2}, 16'h0000);
			w = fw({r[7:0], r[31:17], 1'b0});
			chk("fetch", trd, k == 0 ? w[15:0] : k == 1 ? w[23:16] : w[15:8]);
		end
		base = {r[15:6], 6'h00};
		arow = {r[7:0], base[15:6]};
		for (k = 0; k < 32; k = k + 1) begin
			r = lfsr(r);
			lat[k] = r[23:0];
			tbl(1'b1, 1'b0, 1'b0, base | {k[4:0], 1'b0}, r[15:0]);
			tbl(1'b1, 1'b1, k == 5, base | {k[4:0], 1'b0}, r[31:16]);
		end
		sfr_r(A_LOW, d);
		chk("cap_low", d, base | 16'h003e);
		sfr_r(A_UP, d);
		chk("cap_up", d, arow[17:10]);
		nw = 0;
		nb = 0;
		sfr_w(A_CTL, 16'h4001);
		run(16'hc001, 0);
		chk("stall_len", n, 64);
		chk("prog_words", nw, 32);
		chk("prog_bad", nb, 0);
		sfr_r(A_CTL, d);
		chk("go_clear", d[15], 0);
		clr_done;
		r = lfsr(r);
		sfr_w(A_CTL, 16'h4041);
		sfr_w(A_UP, {8'h00, r[23:16]});
		sfr_w(A_LOW, r[15:0]);
		erow = 0;
		run(16'hc041, 1);
		chk("erase_row", erow, {r[23:16], r[15:6]});
		clr_done;
		for (k = 0; k < 4; k = k + 1) begin
			sfr_w(A_KEY, k == 0 ? 16'h0054 : 16'h0055);
			if (k == 1)
				sfr_w(A_LOW, r[15:0]);
			sfr_w(A_KEY, k == 2 ? 16'h00ab : 16'h00aa);
			sfr_w(A_CTL, k == 3 ? 16'h8001 : 16'hc001);
			chk("no_start", stall, 0);
		end
		sfr_w(A_CTL, 16'h4001);
		run(16'hc001, 2);
		chk("abort_len", n, 1);
		sfr_r(A_CTL, d);
		chk("abort_ctl", d & 16'ha000, 16'h2000);
		sfr_r(A_LOW, d);
		chk("abort_adr", d, r[15:0]);
		chk("abort_flg", dflag, 0);
		end_of_test;
	end
endmodule // fsps_top_tb
